//--- core/tdf_core.sv
// Touch detection, reference hold timeout and option byte decode
`timescale 1ns/1ps
// How it works
// - Detection entry freezes the tracking filter
// - Freeze ends after configured hold timeout
// - Past timeout, tracking resumes during detection
// - After release, small difference reports no detection
// - Masked window arises from tracking itself
// - Debounce samples with filter against noise
// - Separate consecutive counts for entry, exit
// - Configuration comes from option bytes
// - Blank option bytes read zero, defaults
// - Sampling bit selects 20 or 10 ms
// - Transfer bit selects 125 or 250 kHz
// - Power mode field decode, bits 7:6
// - Threshold field decode, bits 5:4
// - Freeze timeout field: 15s, 45s, infinite
// - Output mode field decode, bits 1:0
// - Detection is high, no detection low
// - Detect when reference exceeds signal by threshold
// - Reference is unity-gain first-order low-pass
module tdf_core
  import tdf_pkg::*;
#(
  parameter int P_SLOW_CYC = SLOW_CYC,
  parameter int P_FAST_CYC = FAST_CYC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire tdf_avs_req_t i_avs,
  output logic [31:0]       o_avs_readdata,
  output logic              o_avs_waitrequest,
  input  wire logic         i_smp_valid,
  input  wire logic [15:0]  i_smp_count,
  output logic              o_detect,
  output logic              o_ref_frozen,
  output logic [15:0]       o_reference,
  output logic              o_period_tick,
  output logic              o_fast_sample,
  output logic              o_fast_transfer,
  output logic [1:0]        o_power_mode,
  output logic [1:0]        o_threshold_sel,
  output logic [1:0]        o_output_mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam tdf_state_t RST_STATE = '{
    st:     ST_TRACK,
    det:    1'b0,
    frz:    1'b0,
    cal:    1'b0,
    deb:    3'h0,
    hold:   13'h0000,
    tick:   20'h00000,
    tick_p: 1'b0,
    acc:    20'h00000,
    sig:    16'h0000,
    power_threshold_output_options:   OPT_RST,
    sampling_and_transfer_options:   OPT_RST,
    ack:    1'b0,
    wt:     1'b1,
    rdata:  32'h0000_0000
  };

  tdf_state_t  s_q;
  tdf_state_t  s_d;
  logic [19:0] tick_lim;
  logic [12:0] frz_lim;
  logic        frz_inf;
  logic [15:0] thr;
  logic [16:0] diff;
  logic        qual;
  logic [15:0] ref_val;

  // ----------------------------------------------------------------
  // Option decode
  // ----------------------------------------------------------------
  always_comb begin
    if (s_q.sampling_and_transfer_options[SAMPLING_AND_TRANSFER_OPTIONS_SMP]) begin
      tick_lim = 20'(P_FAST_CYC - 1);
    end else begin
      tick_lim = 20'(P_SLOW_CYC - 1);
    end
    frz_inf = (s_q.power_threshold_output_options[FRZ_LO+:2] == FRZ_INF);
    if (s_q.power_threshold_output_options[FRZ_LO+:2] == FRZ_LONG) begin
      frz_lim = s_q.sampling_and_transfer_options[SAMPLING_AND_TRANSFER_OPTIONS_SMP] ? FRZ_L_FAST : FRZ_L_SLOW;
    end else begin
      frz_lim = s_q.sampling_and_transfer_options[SAMPLING_AND_TRANSFER_OPTIONS_SMP] ? FRZ_S_FAST : FRZ_S_SLOW;
    end
    case (s_q.power_threshold_output_options[THR_LO+:2])
      2'h0:    thr = THR_STD_PROX;
      2'h1:    thr = THR_STD_TCH;
      2'h2:    thr = THR_SNS_PROX;
      default: thr = THR_SNS_TCH;
    endcase
  end

  // ----------------------------------------------------------------
  // Qualifying compare
  // ----------------------------------------------------------------
  assign ref_val = s_q.acc[19:4];
  assign diff = {1'b0, ref_val} - {1'b0, i_smp_count};
  assign qual = !diff[16] && (diff[15:0] >= thr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.tick_p = 1'b0;

    // Avalon slave, one wait state
    if (i_avs.address == REG_POWER_THRESHOLD_OUTPUT_OPTIONS) begin
      rd = {24'h00_0000, s_q.power_threshold_output_options};
    end else if (i_avs.address == REG_SAMPLING_AND_TRANSFER_OPTIONS) begin
      rd = {24'h00_0000, s_q.sampling_and_transfer_options};
    end else if (i_avs.address == REG_STATUS) begin
      rd = {16'h0000, s_q.hold, s_q.cal, s_q.frz, s_q.det};
    end else if (i_avs.address == REG_LEVELS) begin
      rd = {s_q.sig, ref_val};
    end
    if ((i_avs.read || i_avs.write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = i_avs.read ? rd : 32'h0000_0000;
      if (i_avs.write) begin
        if (i_avs.address == REG_POWER_THRESHOLD_OUTPUT_OPTIONS) begin
          s_d.power_threshold_output_options = i_avs.writedata[7:0];
        end else if (i_avs.address == REG_SAMPLING_AND_TRANSFER_OPTIONS) begin
          s_d.sampling_and_transfer_options = i_avs.writedata[7:0] & SAMPLING_AND_TRANSFER_OPTIONS_MASK;
        end
      end
    end
    s_d.wt = !s_d.ack;

    // Sampling period ticks
    if (s_q.tick >= tick_lim) begin
      s_d.tick = 20'h00000;
      s_d.tick_p = 1'b1;
    end else begin
      s_d.tick = s_q.tick + 20'h00001;
    end

    if (i_smp_valid) begin
      s_d.sig = i_smp_count;
      if (!s_q.cal) begin
        s_d.cal = 1'b1;
        s_d.acc = {i_smp_count, 4'h0};
      end else begin
        if (s_q.st != ST_HOLD) begin
          s_d.acc = s_q.acc - {4'h0, s_q.acc[19:4]}
                  + {4'h0, i_smp_count};
        end
        case (s_q.st)
          ST_TRACK: begin
            if (!qual) begin
              s_d.deb = 3'h0;
            end else if (s_q.deb == ENTRY_DEB - 3'h1) begin
              s_d.st = ST_HOLD;
              s_d.deb = 3'h0;
              s_d.hold = 13'h0000;
            end else begin
              s_d.deb = s_q.deb + 3'h1;
            end
          end
          default: begin
            if (qual) begin
              s_d.deb = 3'h0;
            end else if (s_q.deb == EXIT_DEB - 3'h1) begin
              s_d.st = ST_TRACK;
              s_d.deb = 3'h0;
            end else begin
              s_d.deb = s_q.deb + 3'h1;
            end
          end
        endcase
      end
    end

    if (s_d.st == ST_TRACK) begin
      s_d.hold = 13'h0000;
    end else if (s_q.st == ST_HOLD && s_d.st == ST_HOLD
                 && s_q.tick_p && !frz_inf) begin
      if (s_q.hold >= frz_lim - 13'h0001) begin
        s_d.st = ST_DRIFT;
      end else begin
        s_d.hold = s_q.hold + 13'h0001;
      end
    end

    s_d.det = (s_d.st != ST_TRACK);
    s_d.frz = (s_d.st == ST_HOLD);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_readdata    = s_q.rdata;
  assign o_avs_waitrequest = s_q.wt;
  assign o_detect          = s_q.det;
  assign o_ref_frozen      = s_q.frz;
  assign o_reference       = s_q.acc[19:4];
  assign o_period_tick     = s_q.tick_p;
  assign o_fast_transfer   = s_q.sampling_and_transfer_options[SAMPLING_AND_TRANSFER_OPTIONS_XFR];
  assign o_fast_sample     = s_q.sampling_and_transfer_options[SAMPLING_AND_TRANSFER_OPTIONS_SMP];
  assign o_power_mode      = s_q.power_threshold_output_options[PWR_LO+:2];
  assign o_threshold_sel   = s_q.power_threshold_output_options[THR_LO+:2];
  assign o_output_mode     = s_q.power_threshold_output_options[OUT_LO+:2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_hold_ref;
    (s_q.st == ST_HOLD) |=> (s_q.acc == $past(s_q.acc));
  endproperty
  a_hold_ref: assert property (p_hold_ref)
    else $error("reference moved while frozen");

  property p_timeout;
    (s_q.st == ST_HOLD && s_q.tick_p && !frz_inf
     && s_q.hold >= frz_lim - 13'h0001) |=> (s_q.st != ST_HOLD);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("freeze outlived its timeout");

  property p_no_early_drift;
    (s_q.st == ST_HOLD) ##1 (s_q.st == ST_DRIFT)
      |-> $past(s_q.hold) >= $past(frz_lim) - 13'h0001;
  endproperty
  a_no_early_drift: assert property (p_no_early_drift)
    else $error("tracking resumed before timeout");

  property p_entry;
    $rose(s_q.det) |-> $past(s_q.deb) == ENTRY_DEB - 3'h1
                       && $past(i_smp_valid) && $past(qual);
  endproperty
  a_entry: assert property (p_entry)
    else $error("detection entered without full debounce");

  property p_exit;
    $fell(s_q.det) |-> $past(s_q.deb) == EXIT_DEB - 3'h1
                       && $past(i_smp_valid) && !$past(qual);
  endproperty
  a_exit: assert property (p_exit)
    else $error("detection left without full debounce");

  property p_infinite;
    (frz_inf && s_q.st == ST_HOLD) |=> (s_q.st != ST_DRIFT);
  endproperty
  a_infinite: assert property (p_infinite)
    else $error("infinite freeze released");

  property p_hold_clear;
    (s_q.st == ST_TRACK) |-> (s_q.hold == 13'h0000);
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("hold counter not cleared");

  property p_det_level;
    (o_detect == (s_q.st != ST_TRACK))
      and (o_ref_frozen == (s_q.st == ST_HOLD));
  endproperty
  a_det_level: assert property (p_det_level)
    else $error("detect level disagrees with state");

  property p_opt_write;
    (i_avs.write && !s_q.ack && i_avs.address == REG_SAMPLING_AND_TRANSFER_OPTIONS)
      |=> (s_q.sampling_and_transfer_options == ($past(i_avs.writedata[7:0]) & SAMPLING_AND_TRANSFER_OPTIONS_MASK));
  endproperty
  a_opt_write: assert property (p_opt_write)
    else $error("option write not stored masked");

  property p_tick;
    s_q.tick_p |-> $past(s_q.tick) >= $past(tick_lim);
  endproperty
  a_tick: assert property (p_tick)
    else $error("period tick at wrong count");

  property p_power_threshold_output_options_write;
    (i_avs.write && !s_q.ack && i_avs.address == REG_POWER_THRESHOLD_OUTPUT_OPTIONS)
      |=> (s_q.power_threshold_output_options == $past(i_avs.writedata[7:0]));
  endproperty
  a_power_threshold_output_options_write: assert property (p_power_threshold_output_options_write)
    else $error("option write not stored");

  property p_det_on_sample;
    $changed(s_q.det) |-> $past(i_smp_valid);
  endproperty
  a_det_on_sample: assert property (p_det_on_sample)
    else $error("detection changed without a sample");

  property p_ref_toward;
    (s_q.st != ST_HOLD && s_q.cal && i_smp_valid
     && i_smp_count < o_reference) |=> o_reference <= $past(o_reference);
  endproperty
  a_ref_toward: assert property (p_ref_toward)
    else $error("reference moved away from the signal");

  property p_ack;
    (!o_avs_waitrequest) |=> o_avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack)
    else $error("waitrequest low for more than a cycle");

endmodule

//--- inc/tdf_pkg.sv
// Constants, state and bus types for the touch detect and option decode core
package tdf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int SLOW_MS      = 20;
  localparam int FAST_MS      = 10;
  localparam int SLOW_CYC     = CLK_HZ / 1000 * SLOW_MS;
  localparam int FAST_CYC     = CLK_HZ / 1000 * FAST_MS;
  localparam int FRZ_SHORT_MS = 15_000;
  localparam int FRZ_LONG_MS  = 45_000;
  localparam logic [12:0] FRZ_S_SLOW = 13'(FRZ_SHORT_MS / SLOW_MS);
  localparam logic [12:0] FRZ_S_FAST = 13'(FRZ_SHORT_MS / FAST_MS);
  localparam logic [12:0] FRZ_L_SLOW = 13'(FRZ_LONG_MS / SLOW_MS);
  localparam logic [12:0] FRZ_L_FAST = 13'(FRZ_LONG_MS / FAST_MS);

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_POWER_THRESHOLD_OUTPUT_OPTIONS   = 5'h00;
  localparam logic [4:0] REG_SAMPLING_AND_TRANSFER_OPTIONS   = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_LEVELS = 5'h0C;
  localparam logic [7:0] OPT_RST    = 8'h00;
  localparam logic [7:0] SAMPLING_AND_TRANSFER_OPTIONS_MASK  = 8'h06;
  localparam int SAMPLING_AND_TRANSFER_OPTIONS_SMP = 2;
  localparam int SAMPLING_AND_TRANSFER_OPTIONS_XFR = 1;
  localparam int PWR_LO   = 6;
  localparam int THR_LO   = 4;
  localparam int FRZ_LO   = 2;
  localparam int OUT_LO   = 0;
  localparam logic [1:0] FRZ_LONG = 2'h1;
  localparam logic [1:0] FRZ_INF  = 2'h3;

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  localparam logic [2:0]  ENTRY_DEB    = 3'h4;
  localparam logic [2:0]  EXIT_DEB     = 3'h3;
  localparam logic [15:0] THR_STD_PROX = 16'h0010;
  localparam logic [15:0] THR_STD_TCH  = 16'h0040;
  localparam logic [15:0] THR_SNS_PROX = 16'h0008;
  localparam logic [15:0] THR_SNS_TCH  = 16'h0020;

  typedef enum logic [1:0] {ST_TRACK, ST_HOLD, ST_DRIFT} tdf_st_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } tdf_avs_req_t;

  typedef struct packed {
    tdf_st_t     st;
    logic        det;
    logic        frz;
    logic        cal;
    logic [2:0]  deb;
    logic [12:0] hold;
    logic [19:0] tick;
    logic        tick_p;
    logic [19:0] acc;
    logic [15:0] sig;
    logic [7:0]  power_threshold_output_options;
    logic [7:0]  sampling_and_transfer_options;
    logic        ack;
    logic        wt;
    logic [31:0] rdata;
  } tdf_state_t;

endpackage

//--- verif/tdf_afe_model.sv
// Charge-transfer acquisition front end model
`timescale 1ns/1ps
module tdf_afe_model #(
  parameter int P_BURST = 2
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [15:0] i_level,
  output logic             o_smp_valid,
  output logic [15:0]      o_smp_count
);
  int          cnt;
  logic [15:0] lvl;
  // Burst, then one-cycle count; count line scrambled outside valid
  always_ff @(posedge i_clk) begin
    o_smp_valid <= 1'b0;
    o_smp_count <= ~o_smp_count;
    if (!i_rst_n) begin
      cnt         <= 0;
      o_smp_count <= 16'h5A5A;
    end else if (i_start) begin
      cnt <= P_BURST;
      lvl <= i_level;
    end else if (cnt == 1) begin
      cnt         <= 0;
      o_smp_valid <= 1'b1;
      o_smp_count <= lvl;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- verif/touch_detect_freeze_and_option_decode_tb_top.sv
// Self-checking bench for the touch detect and option decode core
`timescale 1ns/1ps
module touch_detect_freeze_and_option_decode_tb_top;
  import tdf_pkg::*;
  localparam int PS = 16;
  localparam int PF = 8;
  logic         i_clk, i_rst_n, st, vld, det, frz, tick, fs, ft, wq;
  tdf_avs_req_t avs;
  logic [15:0]  lvl, cnt, ref_o, ref_q;
  logic [19:0]  ea;
  logic [31:0]  rd, rdo;
  logic [1:0]   pm, ts, om;
  logic [7:0]   r;
  int           n_errors, total_checks, seed, n, k, p;

  tdf_core #(
    .P_SLOW_CYC (PS),
    .P_FAST_CYC (PF)
  ) tdf_core_i (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_avs             (avs),
    .o_avs_readdata    (rdo),
    .o_avs_waitrequest (wq),
    .i_smp_valid       (vld),
    .i_smp_count       (cnt),
    .o_detect          (det),
    .o_ref_frozen      (frz),
    .o_reference       (ref_o),
    .o_period_tick     (tick),
    .o_fast_sample     (fs),
    .o_fast_transfer   (ft),
    .o_power_mode      (pm),
    .o_threshold_sel   (ts),
    .o_output_mode     (om)
  );

  tdf_afe_model tdf_afe_model_i (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_start     (st),
    .i_level     (lvl),
    .o_smp_valid (vld),
    .o_smp_count (cnt)
  );

  // ----------------------------------------------------------------
  // Checks and report
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang;
    n_errors++;
    close_out();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo,
                        input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs <= '{read: !w, write: w, address: a, writedata: d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) hang();
    q = rdo;
    avs <= '0;
    @(posedge i_clk);
  endtask

  task automatic smp(input logic [15:0] v);
    st  <= 1'b1;
    lvl <= v;
    @(posedge i_clk);
    st <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (vld !== 1'b1 && n < 10);
    if (n >= 10) hang();
    repeat (2) @(posedge i_clk);
  endtask

  task automatic period(output int q);
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (tick !== 1'b1) hang();
    q = 0;
    do begin
      @(posedge i_clk);
      q++;
    end while (tick !== 1'b1 && q < 100);
    if (tick !== 1'b1) hang();
  endtask

  // Counts period ticks until the freeze ends
  task automatic thaw(output int q);
    q = 0;
    n = 0;
    while (frz === 1'b1 && n < 14000) begin
      @(posedge i_clk);
      n++;
      if (tick === 1'b1) q++;
    end
    if (frz === 1'b1) hang();
  endtask

  // Unity gain low pass, one sample step
  function automatic logic [19:0] iir(input logic [19:0] a,
                                      input logic [15:0] v);
    return a - {4'h0, a[19:4]} + {4'h0, v};
  endfunction

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 51;
    n_errors = 0;
    total_checks = 0;
    i_rst_n = 1'b0;
    st = 1'b0;
    lvl = 16'h0000;
    avs = '0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    bus(1'b0, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, REG_SAMPLING_AND_TRANSFER_OPTIONS, 32'h0, rd);
    chk(rd, 32'h0);
    chk({det, frz, pm, ts, om, fs, ft}, 32'h0);
    bus(1'b0, 5'h10, 32'h0, rd);
    chk(rd, 32'h0);
    for (k = 0; k < 10; k++) begin
      r = (k == 0) ? 8'hFF : 8'($random(seed));
      bus(1'b1, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, {24'($random(seed)), r}, rd);
      bus(1'b1, REG_SAMPLING_AND_TRANSFER_OPTIONS, {24'hFFFFFF, ~r}, rd);
      bus(1'b0, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h0, rd);
      chk(rd, {24'h0, r});
      chk({pm, ts, om}, {r[7:6], r[5:4], r[1:0]});
      chk({fs, ft}, {~r[2], ~r[1]});
      bus(1'b0, REG_SAMPLING_AND_TRANSFER_OPTIONS, 32'h0, rd);
      chk(rd, {24'h0, ~r & SAMPLING_AND_TRANSFER_OPTIONS_MASK});
    end
    bus(1'b1, REG_SAMPLING_AND_TRANSFER_OPTIONS, 32'h0, rd);
    period(p);
    chk(p, PS);
    bus(1'b1, REG_SAMPLING_AND_TRANSFER_OPTIONS, 32'h4, rd);
    period(p);
    chk(p, PF);
    bus(1'b1, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h0, rd);
    smp(16'd1000);
    chk(ref_o, 16'd1000);
    repeat (3) smp(16'd900);
    smp(16'd1000);
    repeat (3) smp(16'd900);
    chk({det, frz}, 2'b00);
    smp(16'd900);
    chk({det, frz}, 2'b11);
    ea = {16'd1000, 4'h0};
    for (k = 0; k < 8; k++) begin
      ea = iir(ea, (k == 3) ? 16'd1000 : 16'd900);
    end
    ref_q = ea[19:4];
    chk(ref_o, ref_q);
    smp(16'd800);
    chk(ref_o, ref_q);
    thaw(k);
    chk_in(k, FRZ_S_FAST - 1, FRZ_S_FAST + 1);
    chk(det, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, {16'h0000, FRZ_S_FAST - 13'h0001, 3'b101});
    bus(1'b0, REG_LEVELS, 32'h0, rd);
    chk(rd, {16'd800, ref_q});
    p = 0;
    while (det === 1'b1 && p < 100) begin
      smp(16'd900);
      p++;
    end
    if (det === 1'b1) hang();
    chk(det, 1'b0);
    chk(ref_o < ref_q, 1'b1);
    chk(ref_o < 16'd916, 1'b1);
    bus(1'b1, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h0C, rd);
    repeat (4) smp(16'd800);
    chk(frz, 1'b1);
    repeat (13000) @(posedge i_clk);
    chk(frz, 1'b1);
    bus(1'b1, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h04, rd);
    repeat (13000) @(posedge i_clk);
    chk(frz, 1'b1);
    repeat (2) smp(16'd1000);
    chk(det, 1'b1);
    smp(16'd1000);
    chk({det, frz}, 2'b00);
    // Mid-run reset, then touch threshold and reserved timeout code
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    chk({det, frz, ref_o}, 32'h0);
    bus(1'b0, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, REG_POWER_THRESHOLD_OUTPUT_OPTIONS, 32'h18, rd);
    smp(16'd1000);
    repeat (4) smp(16'd960);
    chk({det, frz}, 2'b00);
    repeat (4) smp(16'd900);
    chk({det, frz}, 2'b11);
    ea = {16'd1000, 4'h0};
    for (k = 0; k < 8; k++) begin
      ea = iir(ea, (k < 4) ? 16'd960 : 16'd900);
    end
    chk(ref_o, ea[19:4]);
    thaw(k);
    chk_in(k, FRZ_S_SLOW - 2, FRZ_S_SLOW + 1);
    chk(det, 1'b1);
    close_out();
  end
endmodule
